// *** rtl/fraction_integer_divide_unit.sv ***
// Fraction and integer divide datapath with setup, step and finish phases
`timescale 1ns/1ps

module fraction_integer_divide_unit
	import div_unit_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Request from sequencer
	input wire logic start_i,
	input wire div_request_t req_i,
	// Divisor word fetched from core
	input wire logic divisor_valid_i,
	input wire logic [17:0] divisor_i,
	// Sequencer handshake
	output logic busy_o,
	output logic divisor_req_o,
	output logic done_o,
	output logic skip_next_o,
	// Results
	output div_result_t result_o
);

	if (WORD_W != 18 || STEP_W != 6) begin : g_width_check
		$error("Divide unit supports only 18-bit words with a 6-bit step counter");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_CHECK = 3'b010,
		ST_STEP = 3'b011,
		ST_FINISH = 3'b100
	} state_t;

	state_t state;
	div_op_t op;
	logic [17:0] working;
	logic [17:0] quotient;
	logic [17:0] divisor;
	logic [5:0] step;
	logic link;
	logic dividend_sign;
	logic divisor_sign;
	logic overflow;
	logic signed_op;
	logic [18:0] trial;
	logic [17:0] next_working;
	logic [17:0] next_quotient;
	logic next_bit;
	logic overflow_now;
	logic [5:0] steps_left;
	logic shift_en;

	assign signed_op = (op != OP_UNSIGNED_INTEGER);

	////////////////////////////////////////////////////////////////////////
	// Leading steps idle so the quotient lands at the right binary point
	always_comb begin
		steps_left = STEP_DONE - step;
		if (op == OP_SIGNED_FRACTION) begin
			shift_en = (steps_left != 6'h00) && (steps_left <= 6'(WORD_W - 1));
		end else begin
			shift_en = (steps_left != 6'h00) && (steps_left <= 6'(WORD_W));
		end
	end

	// Overflow test on the captured divisor, used in the check state
	always_comb begin
		if (op == OP_SIGNED_FRACTION) begin
			overflow_now = (divisor <= working);
		end else begin
			overflow_now = (divisor == WORD_ZERO);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Restoring divide step on magnitude working:quotient
	always_comb begin
		trial = {working, quotient[17]} - {1'b0, divisor};
		next_bit = ~trial[18];
		next_working = next_bit ? trial[17:0] : {working[16:0], quotient[17]};
		next_quotient = {quotient[16:0], next_bit};
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_i) begin
						state <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (divisor_valid_i) begin
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					state <= overflow_now ? ST_FINISH : ST_STEP;
				end
				ST_STEP: begin
					if (step == STEP_DONE) begin
						state <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Setup, divisor capture and division steps
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			op <= OP_SIGNED_FRACTION;
			working <= WORD_ZERO;
			quotient <= WORD_ZERO;
			divisor <= WORD_ZERO;
			step <= STEP_DONE;
			dividend_sign <= 1'b0;
			divisor_sign <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_i) begin
						op <= req_i.op;
						step <= req_i.step_field;
						divisor_sign <= req_i.link;
						case (req_i.op)
							OP_SIGNED_FRACTION: begin
								// Fraction in working, point after sign
								dividend_sign <= req_i.working[SIGN_BIT];
								working <= req_i.working[SIGN_BIT] ?
									~req_i.working : req_i.working;
								quotient <= WORD_ZERO;
							end
							OP_SIGNED_INTEGER: begin
								dividend_sign <= req_i.working[SIGN_BIT];
								quotient <= req_i.working[SIGN_BIT] ?
									~req_i.working : req_i.working;
								working <= WORD_ZERO;
							end
							default: begin
								dividend_sign <= 1'b0;
								quotient <= req_i.working;
								working <= WORD_ZERO;
							end
						endcase
					end
				end
				ST_FETCH: begin
					if (divisor_valid_i) begin
						divisor <= divisor_i;
					end
				end
				ST_STEP: begin
					step <= step + 6'h01;
					if (shift_en) begin
						working <= next_working;
						quotient <= next_quotient;
					end
				end
				ST_FINISH: begin
					if (signed_op && !overflow) begin
						// Ones-complement magnitudes with signs on top
						working <= dividend_sign ? ~working : working;
						quotient <= (dividend_sign ^ divisor_sign) ?
							~quotient : quotient;
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow detection and Link
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			overflow <= 1'b0;
		end else if (state == ST_IDLE && start_i) begin
			overflow <= 1'b0;
		end else if (state == ST_CHECK) begin
			overflow <= overflow_now;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			link <= 1'b0;
		end else if (state == ST_FINISH) begin
			link <= overflow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= (state == ST_FINISH);
		end
	end

	assign busy_o = (state != ST_IDLE);
	assign divisor_req_o = (state == ST_FETCH);
	assign skip_next_o = done_o;
	assign result_o.working = working;
	assign result_o.quotient = quotient;
	assign result_o.link = link;
	assign result_o.overflow = overflow;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_launch;
		state == ST_IDLE && start_i;
	endsequence

	sequence s_fetch_done;
		state == ST_FETCH && divisor_valid_i;
	endsequence

	property p_step_load;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_launch |=> step == $past(req_i.step_field);
	endproperty
	a_step_load: assert property (p_step_load) else $error("step counter not loaded");

	property p_frac_setup;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_launch ##0 (req_i.op == OP_SIGNED_FRACTION) |=> quotient == WORD_ZERO
			&& working == ($past(req_i.working[17]) ? ~$past(req_i.working) :
			$past(req_i.working));
	endproperty
	a_frac_setup: assert property (p_frac_setup) else $error("fraction setup wrong");

	property p_uint_setup;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_launch ##0 (req_i.op == OP_UNSIGNED_INTEGER) |=> working == WORD_ZERO
			&& quotient == $past(req_i.working);
	endproperty
	a_uint_setup: assert property (p_uint_setup) else $error("integer setup wrong");

	property p_sint_setup;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_launch ##0 (req_i.op == OP_SIGNED_INTEGER) |=> working == WORD_ZERO
			&& quotient[17] == 1'b0;
	endproperty
	a_sint_setup: assert property (p_sint_setup) else $error("signed setup wrong");

	property p_divisor_taken;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_fetch_done |=> divisor == $past(divisor_i) && state == ST_CHECK;
	endproperty
	a_divisor_taken: assert property (p_divisor_taken) else $error("divisor not taken");

	property p_zero_overflow;
		@(posedge ref_clk_i) disable iff (rst_i)
		state == ST_CHECK && op != OP_SIGNED_FRACTION |=>
			overflow == (divisor == WORD_ZERO);
	endproperty
	a_zero_overflow: assert property (p_zero_overflow) else $error("integer overflow wrong");

	property p_link_result;
		@(posedge ref_clk_i) disable iff (rst_i)
		state == ST_FINISH |=> link == $past(overflow) && state == ST_IDLE;
	endproperty
	a_link_result: assert property (p_link_result) else $error("Link not updated");

	property p_frac_overflow;
		@(posedge ref_clk_i) disable iff (rst_i)
		state == ST_CHECK && op == OP_SIGNED_FRACTION && divisor <= working
			|=> ##1 link;
	endproperty
	a_frac_overflow: assert property (p_frac_overflow) else $error("overflow Link not set");

	property p_step_bound;
		@(posedge ref_clk_i) disable iff (rst_i)
		state == ST_CHECK && step == STEP_LOAD |=> ##[1:21] done_o;
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("divide did not end");

	property p_quot_sign;
		@(posedge ref_clk_i) disable iff (rst_i)
		state == ST_FINISH && signed_op && !overflow && quotient[17] == 1'b0 |=>
			quotient[17] == (dividend_sign ^ divisor_sign);
	endproperty
	a_quot_sign: assert property (p_quot_sign) else $error("quotient sign wrong");

endmodule

// *** rtl/div_unit_pkg.sv ***
// Shared types and constants for the fraction and integer divide unit
package div_unit_pkg;
	localparam int WORD_W = 18;
	localparam int STEP_W = 6;
	// Step counter load: twos complement of octal 23 (19 steps)
	localparam logic [5:0] STEP_LOAD = 6'h2D;
	localparam logic [5:0] STEP_DONE = 6'h00;
	localparam logic [17:0] WORD_ZERO = 18'h00000;
	localparam int SIGN_BIT = 17;

	typedef enum logic [1:0] {
		OP_SIGNED_FRACTION = 2'b00,
		OP_UNSIGNED_INTEGER = 2'b01,
		OP_SIGNED_INTEGER = 2'b10
	} div_op_t;

	typedef struct packed {
		div_op_t op;
		logic [5:0] step_field;
		logic [17:0] working;
		logic link;
	} div_request_t;

	typedef struct packed {
		logic [17:0] working;
		logic [17:0] quotient;
		logic link;
		logic overflow;
	} div_result_t;
endpackage

// *** tb/divisor_memory_model.sv ***
// Core memory stand-in that answers the divisor fetch
`timescale 1ns/1ps
module divisor_memory_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Fetch handshake
	input wire logic fetch_i,
	input wire logic [3:0] delay_i,
	input wire logic [17:0] word_i,
	output logic valid_o,
	output logic [17:0] data_o
);
	logic [3:0] wait_cnt;
	logic [17:0] last;

	assign valid_o = fetch_i && (wait_cnt >= delay_i);
	// Word after the instruction, read only, never written back
	assign data_o = valid_o ? word_i : ~last;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !fetch_i) begin
			wait_cnt <= 4'h0;
		end else if (!valid_o) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// Idle bus shows the inverse of the last word
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			last <= 18'h2AAAA;
		end else if (valid_o) begin
			last <= word_i;
		end
	end
endmodule

// *** tb/fraction_integer_divide_unit_tb.sv ***
// Self-checking bench for the fraction and integer divide unit
`timescale 1ns/1ps
module fraction_integer_divide_unit_tb;
	import div_unit_pkg::*;
	logic ref_clk_i, rst_i, start_i, divisor_valid_i;
	logic busy_o, divisor_req_o, done_o, skip_next_o;
	logic [17:0] divisor_i, word;
	logic [3:0] delay;
	div_request_t req_i;
	div_result_t result_o;
	int error_cnt, tests_run;

	fraction_integer_divide_unit i_fraction_integer_divide_unit (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .start_i(start_i), .req_i(req_i), .divisor_valid_i(divisor_valid_i),
		.divisor_i(divisor_i), .busy_o(busy_o), .divisor_req_o(divisor_req_o),
		.done_o(done_o), .skip_next_o(skip_next_o), .result_o(result_o));
	divisor_memory_model i_divisor_memory_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.fetch_i(divisor_req_o), .delay_i(delay), .word_i(word),
		.valid_o(divisor_valid_i), .data_o(divisor_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_word({17'h0, got}, {17'h0, exp});
	endtask

	// One divide with expectations worked out from operands
	task automatic run_div(input div_op_t op, input logic [17:0] a, input logic l,
		input logic [17:0] b, input logic [3:0] d);
		int n;
		logic [35:0] num;
		logic [17:0] mag, q, r;
		logic neg, ovf, sgn;
		n = 0;
		sgn = (op != OP_UNSIGNED_INTEGER);
		neg = sgn && a[17];
		mag = neg ? ~a : a;
		ovf = (b == WORD_ZERO) || (op == OP_SIGNED_FRACTION && b <= mag);
		num = (op == OP_SIGNED_FRACTION) ? {1'b0, mag, 17'h0} : {18'h0, mag};
		q = ovf ? WORD_ZERO : 18'(num / {18'h0, b});
		r = ovf ? WORD_ZERO : 18'(num % {18'h0, b});
		if (sgn && (l ^ neg)) q = ~q;
		if (neg) r = ~r;
		@(posedge ref_clk_i);
		start_i <= 1'b1;
		req_i <= '{op, STEP_LOAD, a, l};
		word <= b;
		delay <= d;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		#1;
		check_bit(divisor_req_o, 1'b1);
		while (done_o !== 1'b1 && n < 60) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		if (n == 60) begin
			error_cnt++;
			print_verdict();
		end
		check_bit(skip_next_o, 1'b1);
		check_bit(busy_o, 1'b0);
		check_bit(result_o.overflow, ovf);
		check_bit(result_o.link, ovf);
		if (!ovf) begin
			check_word(result_o.quotient, q);
			check_word(result_o.working, r);
			check_word(18'(n), 18'(23 + d));
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic sc_signed_fraction();
		run_div(OP_SIGNED_FRACTION, 18'h08000, 1'b0, 18'h10000, 4'h0);
		run_div(OP_SIGNED_FRACTION, 18'h37FFF, 1'b1, 18'h0C000, 4'h3);
		run_div(OP_SIGNED_FRACTION, 18'h3BFFF, 1'b0, 18'h0C001, 4'h1);
	endtask

	task automatic sc_fraction_overflow();
		run_div(OP_SIGNED_FRACTION, 18'h04000, 1'b0, 18'h04000, 4'h0);
		run_div(OP_SIGNED_FRACTION, 18'h04000, 1'b0, 18'h04001, 4'h2);
	endtask

	task automatic sc_unsigned_integer();
		run_div(OP_UNSIGNED_INTEGER, 18'h3FFFF, 1'b0, 18'h00007, 4'h0);
		run_div(OP_UNSIGNED_INTEGER, 18'h3FFFF, 1'b0, 18'h00001, 4'h5);
		run_div(OP_UNSIGNED_INTEGER, 18'h00123, 1'b0, 18'h00000, 4'h0);
	endtask

	task automatic sc_signed_integer();
		run_div(OP_SIGNED_INTEGER, 18'h3FFF0, 1'b0, 18'h00004, 4'h0);
		run_div(OP_SIGNED_INTEGER, 18'h00123, 1'b1, 18'h00010, 4'h2);
		run_div(OP_SIGNED_INTEGER, 18'h3FF00, 1'b1, 18'h00000, 4'h0);
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		rst_i = 1'b1;
		start_i = 1'b0;
		req_i = '0;
		word = 18'h00000;
		delay = 4'h0;
		error_cnt = 0;
		tests_run = 0;
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		sc_signed_fraction();
		sc_fraction_overflow();
		sc_unsigned_integer();
		sc_signed_integer();
		print_verdict();
	end
endmodule
